/* pkg/cpcri_pkg.sv */
// Purpose: Shared constants for the command register interface
// Assumes: 250 MHz system clock
// Notes:   Field positions, codes and timing counts
package cpcri_pkg;
	localparam int          CPCRI_BIT_RST      = 7;
	localparam int          CPCRI_BIT_GCI      = 6;
	localparam int          CPCRI_BIT_OPC_HI   = 5;
	localparam int          CPCRI_BIT_OPC_LO   = 4;
	localparam int          CPCRI_BIT_RSVD     = 3;
	localparam int          CPCRI_BIT_CH_HI    = 2;
	localparam int          CPCRI_BIT_CH_LO    = 1;
	localparam int          CPCRI_BIT_FLG      = 0;
	localparam logic [7:0]  CPCRI_CMD_RESET    = 8'h00;
	localparam logic [1:0]  CPCRI_OPC_STOP_TX  = 2'h0;
	localparam logic [1:0]  CPCRI_OPC_RESTART  = 2'h1;
	localparam logic [1:0]  CPCRI_OPC_HUNT     = 2'h2;
	localparam logic [1:0]  CPCRI_OPC_RST_BCS  = 2'h3;
	localparam logic [1:0]  CPCRI_GCI_ABORT    = 2'h0;
	localparam logic [1:0]  CPCRI_GCI_TIMEOUT  = 2'h1;
	localparam logic [1:0]  CPCRI_CH_FIRST     = 2'h0;
	localparam logic [1:0]  CPCRI_CH_SECOND    = 2'h1;
	localparam logic [1:0]  CPCRI_CH_THIRD     = 2'h2;
	localparam logic [1:0]  CPCRI_CH_RSVD      = 2'h3;
	localparam logic [1:0]  CPCRI_GCI_CHANNEL  = 2'h2;
	// Execution times in clocks
	localparam logic [7:0]  CPCRI_HUNT_CLKS    = 8'h29;
	localparam logic [7:0]  CPCRI_OTHER_CLKS   = 8'h13;
	localparam logic [7:0]  CPCRI_SRST_FLG_CLKS = 8'h02;
	localparam logic [7:0]  CPCRI_SRST_CLKS    = 8'h3C;
	localparam logic [7:0]  CPCRI_REFRESH_CLKS = 8'h19;
	localparam logic [7:0]  CPCRI_LAT_BISYNC   = 8'hCD;
	localparam logic [7:0]  CPCRI_LAT_HDLC     = 8'hA5;
	localparam logic [7:0]  CPCRI_LAT_UART     = 8'h96;
	localparam logic [7:0]  CPCRI_LAT_DDCMP    = 8'h8C;
	// Protocol enables bit order
	localparam int          CPCRI_PR_BISYNC    = 0;
	localparam int          CPCRI_PR_HDLC      = 1;
	localparam int          CPCRI_PR_TRANSP    = 2;
	localparam int          CPCRI_PR_UART      = 3;
	localparam int          CPCRI_PR_DDCMP     = 4;
	typedef enum logic [3:0] {
		CPCRI_IDLE = 4'h1,
		CPCRI_WAIT = 4'h2,
		CPCRI_EXEC = 4'h4,
		CPCRI_SRST = 4'h8
	} cpcri_state_t;
endpackage

/* pkg/cpcri_exec_if.sv */
// Purpose: Carrier between the controller and its execution timer
// Assumes: Single clock
// Notes:   Start is a pulse; done is a pulse
`timescale 1ns/1ns
interface cpcri_exec_if;
	logic       start;
	logic [7:0] length;
	logic       done;
	modport ctrl  (output start, output length, input done);
	modport timer (input start, input length, output done);
endinterface

/* design/cpcri_timer.sv */
// Purpose: Counts command execution clocks
// Assumes: Synchronous reset copy from the top
// Notes:   Done pulses length clocks after start
`timescale 1ns/1ns
module cpcri_timer (
	input  wire logic      i_clock,
	input  wire logic      i_rst_n,
	cpcri_exec_if.timer    exec
);
	logic [7:0] count_r;
	logic       busy_r;
	logic       done_r;
	wire        last = busy_r && (count_r == 8'h01);
	assign exec.done = done_r;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_r <= 8'h00;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			// A restart cancels the done of the count it replaces
			done_r <= last && !exec.start;
			if (exec.start) begin
				count_r <= exec.length - 8'h01;
				busy_r  <= 1'b1;
			end else if (busy_r) begin
				count_r <= count_r - 8'h01;
				busy_r  <= !last;
			end
		end
	end
endmodule

/* design/cpcri_top.sv */
// Purpose: Command register and decoder of the communications processor
// Assumes: Host writes the command register through a byte write strobe
// Notes:   Actions are one-cycle pulses to the serial controllers
// Behaviour
// - Normal opcodes: stop, restart, hunt, reset block check
// - GCI_COMMAND_SELECT opcodes: abort request, timeout, rest reserved
// - Channel field selects one of three controllers
// - Semaphore set by host, cleared after execution
// - Transmit pin may lag after flag clears
// - Commands after refresh, before channel requests
// - Hunt within 41 clocks, others under 20
// - Latency bound: execution, refresh, protocol term
// - Protocol terms 205, 165, 150, 140, zero
// - Software reset clears flag in two clocks
// - Eight-bit register, field layout, cleared at reset
`timescale 1ns/1ns
module cpcri_top
	import cpcri_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic       i_cmd_write,
	input  wire logic [7:0] i_cmd_wdata,
	input  wire logic       i_refresh_req,
	input  wire logic       i_refresh_enable,
	input  wire logic [4:0] i_proto_enable,
	output logic [7:0]      o_cmd_rdata,
	output logic [2:0]      o_stop_tx,
	output logic [2:0]      o_restart_tx,
	output logic [2:0]      o_enter_hunt,
	output logic [2:0]      o_reset_block_check,
	output logic            o_gci_abort_request,
	output logic            o_gci_timeout,
	output logic            o_soft_reset,
	output logic            o_command_grant,
	output logic [9:0]      o_latency_bound
);
	logic [1:0]   rst_sync_r;
	wire          rst_n = rst_sync_r[1];
	logic [7:0]   cmd_r;
	logic [7:0]   cmd_nxt;
	cpcri_state_t state_r;
	cpcri_state_t state_nxt;
	logic [2:0]   stop_r, restart_r, hunt_r, bcs_r;
	logic         abort_r, timeout_r, srst_r, grant_r;
	logic [9:0]   latency_r;
	cpcri_exec_if exec ();

	function automatic logic [2:0] chan_onehot(input logic [1:0] ch);
		chan_onehot = (ch == CPCRI_CH_RSVD) ? 3'h0 : 3'(3'h1 << ch);
	endfunction

	cpcri_timer u_timer (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.exec    (exec)
	);

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	// Decode of the held command
	wire       gci_sel    = cmd_r[CPCRI_BIT_GCI];
	wire [1:0] opcode     = cmd_r[CPCRI_BIT_OPC_HI:CPCRI_BIT_OPC_LO];
	wire [1:0] target_ch  = cmd_r[CPCRI_BIT_CH_HI:CPCRI_BIT_CH_LO];
	wire [2:0] target_sel = chan_onehot(target_ch);
	wire       flag       = cmd_r[CPCRI_BIT_FLG];
	wire       new_cmd    = i_cmd_write && i_cmd_wdata[CPCRI_BIT_FLG] && !flag;
	wire       new_srst   = i_cmd_write && i_cmd_wdata[CPCRI_BIT_RST];
	// Refresh wins the scheduler over a pending command
	wire       may_run    = (state_r == CPCRI_WAIT) && !i_refresh_req;
	wire       is_hunt    = !gci_sel && (opcode == CPCRI_OPC_HUNT);
	wire [7:0] exec_len   = is_hunt ? CPCRI_HUNT_CLKS : CPCRI_OTHER_CLKS;
	wire       fire       = exec.done && (state_r == CPCRI_EXEC);
	wire       fire_norm  = fire && !gci_sel;
	wire       fire_gci   = fire && gci_sel && (target_ch == CPCRI_GCI_CHANNEL);
	wire [7:0] proto_term = i_proto_enable[CPCRI_PR_BISYNC] ? CPCRI_LAT_BISYNC :
	                        (i_proto_enable[CPCRI_PR_HDLC] || i_proto_enable[CPCRI_PR_TRANSP]) ? CPCRI_LAT_HDLC :
	                        i_proto_enable[CPCRI_PR_UART] ? CPCRI_LAT_UART :
	                        i_proto_enable[CPCRI_PR_DDCMP] ? CPCRI_LAT_DDCMP : 8'h00;
	wire [9:0] lat_nxt    = 10'(CPCRI_HUNT_CLKS) + (i_refresh_enable ? 10'(CPCRI_REFRESH_CLKS) : 10'h000)
	                        + 10'(proto_term);

	// Soft reset restarts the timer from any state but its own
	wire       srst_take  = new_srst && (state_r != CPCRI_SRST);

	assign exec.start  = may_run || srst_take;
	assign exec.length = srst_take ? CPCRI_SRST_CLKS : exec_len;

	always_comb begin
		state_nxt = state_r;
		cmd_nxt   = cmd_r;
		case (state_r)
			CPCRI_IDLE: begin
				if (new_srst) begin
					state_nxt = CPCRI_SRST;
					cmd_nxt   = CPCRI_CMD_RESET;
				end else if (new_cmd) begin
					state_nxt = CPCRI_WAIT;
					cmd_nxt   = i_cmd_wdata & ~(8'h01 << CPCRI_BIT_RSVD);
				end
			end
			CPCRI_WAIT: begin
				if (new_srst) begin
					state_nxt = CPCRI_SRST;
					cmd_nxt   = CPCRI_CMD_RESET;
				end else if (may_run) begin
					state_nxt = CPCRI_EXEC;
				end
			end
			CPCRI_EXEC: begin
				if (new_srst) begin
					state_nxt = CPCRI_SRST;
					cmd_nxt   = CPCRI_CMD_RESET;
				end else if (exec.done) begin
					state_nxt = CPCRI_IDLE;
					cmd_nxt   = CPCRI_CMD_RESET;
				end
			end
			CPCRI_SRST: begin
				if (exec.done) begin
					state_nxt = CPCRI_IDLE;
				end
			end
			default: begin
				state_nxt = CPCRI_IDLE;
				cmd_nxt   = CPCRI_CMD_RESET;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CPCRI_IDLE;
			cmd_r   <= CPCRI_CMD_RESET;
		end else begin
			state_r <= state_nxt;
			cmd_r   <= cmd_nxt;
		end
	end

	// Actions pulse in the cycle the flag clears; drain lag belongs to the controllers
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			stop_r    <= 3'h0;
			restart_r <= 3'h0;
			hunt_r    <= 3'h0;
			bcs_r     <= 3'h0;
			abort_r   <= 1'b0;
			timeout_r <= 1'b0;
			srst_r    <= 1'b0;
			grant_r   <= 1'b0;
			latency_r <= 10'h000;
		end else begin
			stop_r    <= (fire_norm && opcode == CPCRI_OPC_STOP_TX) ? target_sel : 3'h0;
			restart_r <= (fire_norm && opcode == CPCRI_OPC_RESTART) ? target_sel : 3'h0;
			hunt_r    <= (fire_norm && opcode == CPCRI_OPC_HUNT) ? target_sel : 3'h0;
			bcs_r     <= (fire_norm && opcode == CPCRI_OPC_RST_BCS) ? target_sel : 3'h0;
			abort_r   <= fire_gci && opcode == CPCRI_GCI_ABORT;
			timeout_r <= fire_gci && opcode == CPCRI_GCI_TIMEOUT;
			srst_r    <= state_r == CPCRI_SRST && exec.done;
			grant_r   <= may_run;
			latency_r <= lat_nxt;
		end
	end

	assign o_cmd_rdata         = cmd_r;
	assign o_stop_tx           = stop_r;
	assign o_restart_tx        = restart_r;
	assign o_enter_hunt        = hunt_r;
	assign o_reset_block_check = bcs_r;
	assign o_gci_abort_request = abort_r;
	assign o_gci_timeout       = timeout_r;
	assign o_soft_reset        = srst_r;
	assign o_command_grant     = grant_r;
	assign o_latency_bound     = latency_r;
endmodule

/* testbench/cpcri_checker.sv */
// Purpose: Port-level assertions for the command register block
// Assumes: Reset copy releases on the second edge after i_reset_n rises
// Notes:   Bound onto cpcri_top
`timescale 1ns/1ns
module cpcri_checker (
	input wire logic       i_clock,
	input wire logic       i_reset_n,
	input wire logic       i_cmd_write,
	input wire logic [7:0] i_cmd_wdata,
	input wire logic       i_refresh_req,
	input wire logic       i_refresh_enable,
	input wire logic [4:0] i_proto_enable,
	input wire logic [7:0] o_cmd_rdata,
	input wire logic [2:0] o_stop_tx,
	input wire logic [2:0] o_restart_tx,
	input wire logic [2:0] o_enter_hunt,
	input wire logic [2:0] o_reset_block_check,
	input wire logic       o_gci_abort_request,
	input wire logic       o_gci_timeout,
	input wire logic       o_soft_reset,
	input wire logic       o_command_grant,
	input wire logic [9:0] o_latency_bound
);
	logic [1:0]  up_r;
	wire         up = up_r == 2'h3;
	wire  [13:0] acts = {o_stop_tx, o_restart_tx, o_enter_hunt, o_reset_block_check, o_gci_abort_request, o_gci_timeout};
	wire         flag = o_cmd_rdata[0];
	// Hold off until the internal reset copy has let go
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) up_r <= 2'h0;
		else if (!up) up_r <= up_r + 2'h1;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	AST_RSVD_BIT: assert property (o_cmd_rdata[3] == 1'b0) else $error("reserved bit reads one");
	AST_ONE_TARGET: assert property ($onehot0(acts)) else $error("more than one action pulse");
	AST_PULSE_FLAG: assert property (|acts |-> ##[0:2] !flag) else $error("flag kept after action");
	AST_HUNT_TIME: assert property (up && $rose(flag) && !i_refresh_req && o_cmd_rdata[7:4] == 4'h2
		|-> ##[1:42] !flag) else $error("hunt too slow");
	AST_OTHER_TIME: assert property (up && $rose(flag) && !i_refresh_req && o_cmd_rdata[7:4] != 4'h2
		|-> ##[1:20] !flag) else $error("command too slow");
	AST_HOLD: assert property (up && $past(flag) && flag && !$past(i_cmd_write) |-> $stable(o_cmd_rdata))
		else $error("command changed while busy");
	AST_REFRESH_FIRST: assert property (up && i_refresh_req |=> !o_command_grant) else $error("grant over refresh");
	AST_SRST_FLAG: assert property (up && i_cmd_write && i_cmd_wdata[7] |-> ##[1:2] !flag)
		else $error("soft reset flag late");
	AST_LAT_BASE: assert property (up && i_proto_enable == 5'h00 && !i_refresh_enable |=> o_latency_bound == 10'h029)
		else $error("base latency wrong");
	AST_LAT_TOP: assert property (up && i_proto_enable[0] && i_refresh_enable |=> o_latency_bound == 10'h10F)
		else $error("top latency wrong");
	cover property (|o_enter_hunt);
	cover property (o_gci_abort_request);
	cover property (o_soft_reset);
endmodule
bind cpcri_top cpcri_checker cpcri_checker_i (.*);

/* testbench/cpcri_host_model.sv */
// Purpose: Host core writing the command register
// Assumes: Driven at the falling clock edge
// Notes:   Released data shows the inverse of the last value
`timescale 1ns/1ns
module cpcri_host_model (
	input  wire logic       i_clock,
	input  wire logic       i_flag,
	output logic            o_cmd_write,
	output logic [7:0]      o_cmd_wdata
);
	initial begin
		o_cmd_write = 1'b0;
		o_cmd_wdata = 8'h00;
	end
	task automatic put(input logic [7:0] v, input bit polite, output bit ok);
		int n;
		n = 0;
		// Let an edge pass so back-to-back calls never retoggle the strobe
		@(negedge i_clock);
		while (polite && i_flag !== 1'b0 && n < 100) begin
			@(negedge i_clock);
			n++;
		end
		ok = n < 100;
		o_cmd_write = 1'b1;
		o_cmd_wdata = v & 8'hF7;
		@(negedge i_clock);
		o_cmd_write = 1'b0;
		o_cmd_wdata = ~o_cmd_wdata;
	endtask
endmodule

/* testbench/cp_command_register_interface_bench.sv */
// Purpose: Self-checking bench for the command register block
// Assumes: Host model writes, bench watches pulses
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ns
module cp_command_register_interface_bench;
	import cpcri_pkg::*;
	logic        i_clock, i_reset_n, i_refresh_req, i_refresh_enable, cmd_write, abort, tmo, srst, grant, ok;
	logic [4:0]  i_proto_enable;
	logic [7:0]  cmd_wdata, rdata;
	logic [2:0]  stop, rst, hunt, rbc;
	logic [9:0]  lat;
	logic [13:0] acc;
	wire  [13:0] acts = {stop, rst, hunt, rbc, abort, tmo};
	int          num_errors, compares, n;
	cpcri_host_model cpcri_host_model_i (.i_clock(i_clock), .i_flag(rdata[0]), .o_cmd_write(cmd_write),
		.o_cmd_wdata(cmd_wdata));
	cpcri_top cpcri_top_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cmd_write(cmd_write),
		.i_cmd_wdata(cmd_wdata), .i_refresh_req(i_refresh_req), .i_refresh_enable(i_refresh_enable),
		.i_proto_enable(i_proto_enable), .o_cmd_rdata(rdata), .o_stop_tx(stop), .o_restart_tx(rst),
		.o_enter_hunt(hunt), .o_reset_block_check(rbc), .o_gci_abort_request(abort), .o_gci_timeout(tmo),
		.o_soft_reset(srst), .o_command_grant(grant), .o_latency_bound(lat));
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic run(logic [7:0] v);
		cpcri_host_model_i.put(v, 1'b1, ok);
		check("host wait", ok, 1'b1);
		acc = 14'h0000;
		for (n = 0; n < 200 && rdata[0] !== 1'b0; n++) begin
			@(negedge i_clock);
			acc |= acts;
		end
		repeat (2) begin
			@(negedge i_clock);
			acc |= acts;
		end
		check("flag clear", n < 200, 1'b1);
	endtask
	task automatic t_sweep;
		for (int op = 0; op < 4; op++) begin
			for (int ch = 0; ch < 4; ch++) begin
				run({2'h0, op[1:0], 1'b0, ch[1:0], 1'b1});
				check("action", acc, ch == 3 ? 14'h0000 : 14'h0001 << (2 + (3 - op) * 3 + ch));
				check("exec time", n <= (op == 2 ? 42 : 20), 1'b1);
			end
		end
	endtask
	task automatic t_gci;
		for (int op = 0; op < 4; op++) begin
			run({2'h1, op[1:0], 4'h5});
			check("gci action", acc, op == 0 ? 14'h0002 : op == 1 ? 14'h0001 : 14'h0000);
		end
	endtask
	task automatic t_busy;
		cpcri_host_model_i.put(8'h21, 1'b1, ok);
		cpcri_host_model_i.put(8'h03, 1'b0, ok);
		check("busy write", rdata, 8'h21);
		cpcri_host_model_i.put(8'h81, 1'b0, ok);
		@(negedge i_clock);
		check("srst flag", rdata[0], 1'b0);
		for (n = 0; n < 100 && srst !== 1'b1; n++) @(negedge i_clock);
		check("srst done", n < 100, 1'b1);
		check("srst time", n > 50 && n < 70, 1'b1);
	endtask
	task automatic t_refresh;
		logic seen_grant;
		seen_grant = 1'b0;
		i_refresh_req = 1'b1;
		cpcri_host_model_i.put(8'h01, 1'b1, ok);
		acc = 14'h0000;
		repeat (30) begin
			@(negedge i_clock);
			acc |= {acts[12:0], grant};
		end
		check("refresh stall", {acc, rdata[0]}, 15'h0001);
		i_refresh_req = 1'b0;
		acc = 14'h0000;
		for (n = 0; n < 200 && rdata[0] !== 1'b0; n++) begin
			@(negedge i_clock);
			acc |= acts;
			seen_grant |= grant;
		end
		check("after refresh", acc, 14'h0800);
		check("grant", seen_grant, 1'b1);
		run(8'h00);
		check("flagless write", acc, 14'h0000);
	endtask
	task automatic t_latency;
		logic [4:0] pe[8] = '{5'h00, 5'h00, 5'h01, 5'h0A, 5'h04, 5'h08, 5'h10, 5'h18};
		logic [9:0] ex[8] = '{10'h029, 10'h042, 10'h0F6, 10'h0CE, 10'h0CE, 10'h0BF, 10'h0B5, 10'h0BF};
		for (int k = 0; k < 8; k++) begin
			i_proto_enable = pe[k];
			i_refresh_enable = k[0];
			repeat (2) @(negedge i_clock);
			check("latency", lat, ex[k] + (k[0] && k > 2 ? 10'h019 : 10'h000));
		end
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		num_errors = 0;
		compares = 0;
		i_reset_n = 1'b0;
		i_refresh_req = 1'b0;
		i_refresh_enable = 1'b0;
		i_proto_enable = 5'h00;
		repeat (12) @(negedge i_clock);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_clock);
		check("reset value", rdata, 8'h00);
		t_sweep;
		t_gci;
		t_busy;
		t_refresh;
		t_latency;
		print_verdict;
	end
endmodule
